// file: hw/sfsc_map.vh
`ifndef SFSC_MAP_VH
`define SFSC_MAP_VH
// register byte offsets
`define SFSC_CTRL_OFS 8'h00
`define SFSC_STAT_OFS 8'h04
`define SFSC_IP_OFS 8'h08
`define SFSC_RET_OFS 8'h0c
`define SFSC_VEC_OFS 8'h10
`define SFSC_FRB_OFS 8'h14
`define SFSC_OID_OFS 8'h18
`define SFSC_TBL_OFS 8'h1c
// status bits
`define SFSC_ST_RUN 0
`define SFSC_ST_HALT 1
`define SFSC_ST_FLY 2
`define SFSC_ST_ILL 3
// instruction word 0 fields
`define SFSC_CLS_HI 31
`define SFSC_CLS_LO 30
`define SFSC_OP_HI 29
`define SFSC_OP_LO 27
`define SFSC_PH_HI 26
`define SFSC_PH_LO 24
`define SFSC_REL_BIT 23
`define SFSC_CARRY_BIT 21
`define SFSC_TF_BIT 19
`define SFSC_CMPD_BIT 18
`define SFSC_CMPP_BIT 17
`define SFSC_WAIT_BIT 16
`define SFSC_MSK_HI 15
`define SFSC_MSK_LO 8
`define SFSC_DAT_HI 7
`define SFSC_DAT_LO 0
`define SFSC_IO_REL_BIT 26
`define SFSC_IO_TBL_BIT 25
`define SFSC_IO_ATN_BIT 24
`define SFSC_IO_ID_HI 18
`define SFSC_IO_ID_LO 16
// table entry fields
`define SFSC_TE_ID_HI 18
`define SFSC_TE_ID_LO 16
`define SFSC_TE_PER_HI 15
`define SFSC_TE_PER_LO 8
`define SFSC_TE_OFF_HI 7
`define SFSC_TE_OFF_LO 0
// classes and opcodes
`define SFSC_CLS_IO 2'h1
`define SFSC_CLS_TC 2'h2
`define SFSC_OP_JUMP 3'h0
`define SFSC_OP_CALL 3'h1
`define SFSC_OP_RET 3'h2
`define SFSC_OP_INT 3'h3
`define SFSC_OP_FLY 3'h4
`define SFSC_IO_SEL 3'h0
// instruction length in bytes
`define SFSC_INSTR_LEN 32'h0000_0008
`endif

// file: hw/sfsc_core.v
// Contract
// - taken return loads pointer from saved holder
// - taken call saves return address, overwriting
// - wait bit set for waiting form
// - true/false bit cleared when negated
// - phase test compares current bus phase
// - data test compares first received byte
// - phase and data results combined
// - mask bits exclude positions from compare
// - carry test uses carry, stands alone
// - target role tests initiator ATN
// - negated form inverts the plain test
// - halting interrupt stops engine, signals host
// - halting interrupt copies value to vector
// - non-halting interrupt raises, engine continues
// - select/reselect arbitrate with own id
// - select targets destination id after win
// - reselect targets destination id after win
// - lost arbitration jumps to alternate address
// - select with attention asserts ATN
// - table option fetches id, offset, period
// - relative option offsets from pointer
// - relative operand is signed 24 bits
// - reselect target role, select initiator
`timescale 1ns/1ns
`include "sfsc_map.vh"
module sfsc_core (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  output wire fetch_req,
  output wire [31:0] fetch_addr,
  input wire fetch_ack,
  input wire [31:0] fetch_word0,
  input wire [31:0] fetch_word1,
  output wire tbl_req,
  output wire [31:0] tbl_addr,
  input wire tbl_ack,
  input wire [31:0] tbl_data,
  input wire [2:0] bus_phase,
  input wire phase_req,
  input wire atn_in,
  input wire alu_carry,
  output wire arb_req,
  output wire [2:0] arb_id,
  input wire arb_won,
  input wire arb_lost,
  output wire sel_req,
  output reg sel_reselect,
  output reg sel_atn,
  output reg [2:0] sel_dest_id,
  output reg [7:0] sync_period,
  output reg [7:0] sync_offset,
  input wire sel_done,
  output wire int_halt,
  output wire int_fly
);
  localparam ST_IDLE = 3'h0;
  localparam ST_FETCH = 3'h1;
  localparam ST_EXEC = 3'h2;
  localparam ST_WAITPH = 3'h3;
  localparam ST_TBL = 3'h4;
  localparam ST_ARB = 3'h5;
  localparam ST_SEL = 3'h6;

  reg [2:0] state_ff;
  reg [31:0] ip_ff;
  reg [31:0] ret_ff;
  reg [31:0] vec_ff;
  reg [7:0] frb_ff;
  reg [2:0] oid_ff;
  reg [31:0] tblb_ff;
  reg role_tgt_ff;
  reg halt_ff;
  reg fly_ff;
  reg ill_ff;
  reg [31:0] w0_ff;
  reg [31:0] w1_ff;
  reg phw_ff;
  reg [31:0] tbl_addr_ff;

  reg [2:0] nxt_state;
  reg [31:0] nxt_ip;
  reg [31:0] nxt_ret;
  reg [31:0] nxt_vec;
  reg nxt_halt;
  reg nxt_fly_set;
  reg nxt_ill;
  reg nxt_sel_load;
  reg [31:0] nxt_rdata;

  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & ~pwrite;
  wire [7:0] ofs = paddr[7:0];
  wire mapped = (paddr[31:8] == 24'h00_0000) & (ofs[1:0] == 2'h0) &
    (ofs <= `SFSC_TBL_OFS);

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // instruction fields
  wire [1:0] cls = w0_ff[`SFSC_CLS_HI:`SFSC_CLS_LO];
  wire [2:0] opc = w0_ff[`SFSC_OP_HI:`SFSC_OP_LO];
  wire [2:0] want_phase = w0_ff[`SFSC_PH_HI:`SFSC_PH_LO];
  wire [7:0] msk = w0_ff[`SFSC_MSK_HI:`SFSC_MSK_LO];
  wire [7:0] dat = w0_ff[`SFSC_DAT_HI:`SFSC_DAT_LO];
  wire is_wait = w0_ff[`SFSC_WAIT_BIT];
  wire tf_bit = w0_ff[`SFSC_TF_BIT];
  wire cmp_p = w0_ff[`SFSC_CMPP_BIT];
  wire cmp_d = w0_ff[`SFSC_CMPD_BIT];
  wire tst_c = w0_ff[`SFSC_CARRY_BIT];

  // condition evaluation
  wire phase_hit = (want_phase == bus_phase);
  wire atn_hit = atn_in;
  wire p_hit = role_tgt_ff ? atn_hit : phase_hit;
  wire [7:0] diff;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_cmp
      assign diff[gi] = (dat[gi] ^ frb_ff[gi]) & ~msk[gi];
    end
  endgenerate
  wire d_hit = (diff == 8'h00);
  wire pd_res = (cmp_p ? p_hit : 1'b1) & (cmp_d ? d_hit : 1'b1);
  wire c_res = alu_carry;
  wire any_test = tst_c | cmp_p | cmp_d;
  wire res = tst_c ? c_res : pd_res;
  wire taken = ~any_test | (res == tf_bit);

  // relative target from pointer past this instruction
  wire is_rel = (cls == `SFSC_CLS_IO) ? w0_ff[`SFSC_IO_REL_BIT] :
    w0_ff[`SFSC_REL_BIT];
  wire [31:0] disp = {{8{w1_ff[23]}}, w1_ff[23:0]};
  wire [31:0] dest = is_rel ? ip_ff + disp : w1_ff;

  wire io_resel = (opc != `SFSC_IO_SEL);
  wire role_ok = io_resel ? role_tgt_ff : ~role_tgt_ff;
  wire io_tbl = w0_ff[`SFSC_IO_TBL_BIT];
  wire [31:0] tbl_disp = {{8{w0_ff[23]}}, w0_ff[23:0]};

  assign fetch_req = (state_ff == ST_FETCH);
  assign fetch_addr = ip_ff;
  assign tbl_req = (state_ff == ST_TBL);
  assign tbl_addr = tbl_addr_ff;
  assign arb_req = (state_ff == ST_ARB);
  assign arb_id = oid_ff;
  assign sel_req = (state_ff == ST_SEL);
  assign int_halt = halt_ff;
  assign int_fly = fly_ff;

  wire ip_wr = wr_acc & mapped & (ofs == `SFSC_IP_OFS);

  // execution sequencer
  always @* begin
    nxt_state = state_ff;
    nxt_ip = ip_ff;
    nxt_ret = ret_ff;
    nxt_vec = vec_ff;
    nxt_halt = 1'b0;
    nxt_fly_set = 1'b0;
    nxt_ill = 1'b0;
    nxt_sel_load = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (ip_wr) begin
          nxt_ip = pwdata;
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (fetch_ack) begin
          nxt_ip = ip_ff + `SFSC_INSTR_LEN;
          nxt_state = ST_EXEC;
        end
      end
      ST_WAITPH: begin
        if (phase_req) begin
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        nxt_state = ST_FETCH;
        if (cls == `SFSC_CLS_TC) begin
          if (is_wait & cmp_p & ~phw_ff) begin
            nxt_state = ST_WAITPH;
          end else if (taken) begin
            case (opc)
              `SFSC_OP_JUMP: nxt_ip = dest;
              `SFSC_OP_CALL: begin
                nxt_ret = ip_ff;
                nxt_ip = dest;
              end
              `SFSC_OP_RET: nxt_ip = ret_ff;
              `SFSC_OP_INT: begin
                nxt_vec = w1_ff;
                nxt_halt = 1'b1;
                nxt_state = ST_IDLE;
              end
              `SFSC_OP_FLY: nxt_fly_set = 1'b1;
              default: begin
                nxt_ill = 1'b1;
                nxt_state = ST_IDLE;
              end
            endcase
          end
        end else if (cls == `SFSC_CLS_IO && opc <= 3'h1) begin
          if (!role_ok) begin
            nxt_ill = 1'b1;
            nxt_state = ST_IDLE;
          end else if (io_tbl) begin
            nxt_state = ST_TBL;
          end else begin
            nxt_sel_load = 1'b1;
            nxt_state = ST_ARB;
          end
        end else begin
          nxt_ill = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_TBL: begin
        if (tbl_ack) begin
          nxt_state = ST_ARB;
        end
      end
      ST_ARB: begin
        if (arb_lost) begin
          nxt_ip = dest;
          nxt_state = ST_FETCH;
        end else if (arb_won) begin
          nxt_state = ST_SEL;
        end
      end
      ST_SEL: begin
        if (sel_done) begin
          nxt_state = ST_FETCH;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      ip_ff <= 32'h0000_0000;
      ret_ff <= 32'h0000_0000;
      vec_ff <= 32'h0000_0000;
      halt_ff <= 1'b0;
      fly_ff <= 1'b0;
      ill_ff <= 1'b0;
      w0_ff <= 32'h0000_0000;
      w1_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      ip_ff <= nxt_ip;
      ret_ff <= nxt_ret;
      vec_ff <= nxt_vec;
      if (state_ff == ST_FETCH && fetch_ack) begin
        w0_ff <= fetch_word0;
        w1_ff <= fetch_word1;
      end
      // a start clears the halt and error flags
      if (nxt_halt) begin
        halt_ff <= 1'b1;
      end else if (ip_wr && state_ff == ST_IDLE) begin
        halt_ff <= 1'b0;
      end
      if (nxt_ill) begin
        ill_ff <= 1'b1;
      end else if (ip_wr && state_ff == ST_IDLE) begin
        ill_ff <= 1'b0;
      end
      // set wins over a write-one clear
      if (nxt_fly_set) begin
        fly_ff <= 1'b1;
      end else if (wr_acc && mapped && ofs == `SFSC_STAT_OFS &&
        pwdata[`SFSC_ST_FLY]) begin
        fly_ff <= 1'b0;
      end
    end
  end

  // selection operands, direct or from the table
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reselect <= 1'b0;
      sel_atn <= 1'b0;
      sel_dest_id <= 3'h0;
      sync_period <= 8'h00;
      sync_offset <= 8'h00;
    end else begin
      if (nxt_sel_load || (state_ff == ST_EXEC && nxt_state == ST_TBL)) begin
        sel_reselect <= io_resel;
        sel_atn <= w0_ff[`SFSC_IO_ATN_BIT] & ~io_resel;
        sel_dest_id <= w0_ff[`SFSC_IO_ID_HI:`SFSC_IO_ID_LO];
      end
      if (state_ff == ST_TBL && tbl_ack) begin
        sel_dest_id <= tbl_data[`SFSC_TE_ID_HI:`SFSC_TE_ID_LO];
        sync_period <= tbl_data[`SFSC_TE_PER_HI:`SFSC_TE_PER_LO];
        sync_offset <= tbl_data[`SFSC_TE_OFF_HI:`SFSC_TE_OFF_LO];
      end
    end
  end

  // remembers that a phase wait has just been passed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phw_ff <= 1'b0;
    end else begin
      phw_ff <= (state_ff == ST_WAITPH);
    end
  end

  // table entry address, held while the table read is pending
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_addr_ff <= 32'h0000_0000;
    end else if (state_ff == ST_EXEC && nxt_state == ST_TBL) begin
      tbl_addr_ff <= tblb_ff + tbl_disp;
    end
  end

  // software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frb_ff <= 8'h00;
      oid_ff <= 3'h0;
      tblb_ff <= 32'h0000_0000;
      role_tgt_ff <= 1'b0;
    end else if (wr_acc && mapped) begin
      case (ofs)
        `SFSC_CTRL_OFS: role_tgt_ff <= pwdata[0];
        `SFSC_FRB_OFS: frb_ff <= pwdata[7:0];
        `SFSC_OID_OFS: oid_ff <= pwdata[2:0];
        `SFSC_TBL_OFS: tblb_ff <= pwdata;
        default: frb_ff <= frb_ff;
      endcase
    end
  end

  always @* begin
    nxt_rdata = 32'h0000_0000;
    if (rd_acc && mapped) begin
      case (ofs)
        `SFSC_CTRL_OFS: nxt_rdata = {31'h0000_0000, role_tgt_ff};
        `SFSC_STAT_OFS: nxt_rdata = {28'h000_0000, ill_ff, fly_ff, halt_ff,
          (state_ff != ST_IDLE)};
        `SFSC_IP_OFS: nxt_rdata = ip_ff;
        `SFSC_RET_OFS: nxt_rdata = ret_ff;
        `SFSC_VEC_OFS: nxt_rdata = vec_ff;
        `SFSC_FRB_OFS: nxt_rdata = {24'h00_0000, frb_ff};
        `SFSC_OID_OFS: nxt_rdata = {29'h0000_0000, oid_ff};
        `SFSC_TBL_OFS: nxt_rdata = tblb_ff;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // read data launched in the setup cycle stands through the access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= nxt_rdata;
    end
  end
endmodule

// file: dv/sfsc_core_assertions.sv
`timescale 1ns/1ns
module sfsc_core_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] paddr,
  input wire pslverr,
  input wire fetch_req,
  input wire [31:0] fetch_addr,
  input wire fetch_ack,
  input wire tbl_req,
  input wire [31:0] tbl_addr,
  input wire tbl_ack,
  input wire arb_req,
  input wire arb_won,
  input wire arb_lost,
  input wire sel_req,
  input wire sel_atn,
  input wire [2:0] sel_dest_id,
  input wire sel_done,
  input wire int_halt,
  input wire int_fly
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  halt_stops_a: assert property ($rose(int_halt) |-> !fetch_req && !arb_req)
    else $error("engine busy at halt");
  fly_runs_a: assert property ($rose(int_fly) |-> fetch_req && !int_halt)
    else $error("engine stopped at fly");
  win_sel_a: assert property (arb_req && arb_won && !arb_lost |=> sel_req)
    else $error("no selection after win");
  lost_jump_a: assert property (arb_req && arb_lost |=> fetch_req && !sel_req)
    else $error("no fetch after loss");
  arb_hold_a: assert property (arb_req && !arb_won && !arb_lost |=> arb_req)
    else $error("arbitration dropped");
  sel_hold_a: assert property (sel_req && !sel_done |=>
    sel_req && $stable(sel_dest_id) && $stable(sel_atn))
    else $error("selection fields moved");
  sel_end_a: assert property (sel_req && sel_done |=> fetch_req && !sel_req)
    else $error("no fetch after selection");
  fetch_hold_a: assert property (fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_addr))
    else $error("fetch request moved");
  tbl_hold_a: assert property (tbl_req && !tbl_ack |=> tbl_req && $stable(tbl_addr))
    else $error("table request moved");
  unmapped_err_a: assert property (psel && penable && paddr[31:8] != 24'h0 |-> pslverr)
    else $error("unmapped access not refused");
  cover property (int_fly);
  cover property (arb_req && arb_lost);
  cover property (tbl_req && tbl_ack);
endmodule
bind sfsc_core sfsc_core_checker u_sfsc_core_checker (.pclk, .presetn, .psel, .penable,
  .paddr, .pslverr, .fetch_req, .fetch_addr, .fetch_ack, .tbl_req, .tbl_addr, .tbl_ack,
  .arb_req, .arb_won, .arb_lost, .sel_req, .sel_atn, .sel_dest_id, .sel_done, .int_halt,
  .int_fly);

// file: dv/sfsc_peer.sv
`timescale 1ns/1ns
module sfsc_peer (
  input wire pclk,
  input wire fetch_req,
  input wire [31:0] fetch_addr,
  output logic fetch_ack,
  output wire [31:0] fetch_word0,
  output wire [31:0] fetch_word1,
  input wire tbl_req,
  input wire [31:0] tbl_addr,
  output logic tbl_ack,
  output wire [31:0] tbl_data,
  input wire arb_req,
  output logic arb_won,
  output logic arb_lost,
  input wire sel_req,
  output logic sel_done,
  input wire slow,
  input wire lose
);
  logic [31:0] m0 [16];
  logic [31:0] m1 [16];
  logic tog = 1'b0;
  wire [31:0] w0 = m0[fetch_addr[6:3]];
  wire [31:0] w1 = m1[fetch_addr[6:3]];
  // words only valid in the ack cycle, inverted otherwise
  assign fetch_word0 = fetch_ack ? w0 : ~w0;
  assign fetch_word1 = fetch_ack ? w1 : ~w1;
  // offset field echoes the table address low byte
  assign tbl_data = tbl_ack ? {13'h0, 3'h6, 8'h22, tbl_addr[7:0]} : 32'hffff_ffff;
  always @(posedge pclk) begin
    tog <= ~tog;
    fetch_ack <= fetch_req & ~fetch_ack & (~slow | tog);
    tbl_ack <= tbl_req & ~tbl_ack;
    arb_won <= arb_req & ~arb_won & ~arb_lost & ~lose;
    arb_lost <= arb_req & ~arb_won & ~arb_lost & lose;
    sel_done <= sel_req & ~sel_done & tog;
  end
endmodule

// file: dv/test_script_flow_and_select_control.sv
`timescale 1ns/1ns
`include "sfsc_map.vh"
module test_script_flow_and_select_control;
  typedef struct {logic [31:0] w; logic [7:0] b; logic [4:0] f;} sfsc_row_t;
  logic pclk, presetn, psel, penable, pwrite, phase_req, atn_in, alu_carry, slow, lose;
  logic pready, pslverr, fetch_req, fetch_ack, tbl_req, tbl_ack, arb_req, arb_won, arb_lost;
  logic sel_req, sel_reselect, sel_atn, sel_done, int_halt, int_fly;
  logic [31:0] paddr, pwdata, prdata, fetch_addr, fetch_word0, fetch_word1, tbl_addr;
  logic [31:0] tbl_data, d, cap;
  logic sl;
  logic [2:0] bus_phase, arb_id, sel_dest_id;
  logic [7:0] sync_period, sync_offset;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  // f holds carry, atn, target role, wait form, taken
  sfsc_row_t rows [12] = '{'{32'h9808_0000, 8'h00, 5'h01}, '{32'h9a0a_0000, 8'h00, 5'h01},
    '{32'h9b0a_0000, 8'h00, 5'h00}, '{32'h980c_7f80, 8'h85, 5'h01},
    '{32'h980c_0080, 8'h85, 5'h00}, '{32'h9a0e_0085, 8'h85, 5'h01},
    '{32'h9a0e_0084, 8'h85, 5'h00}, '{32'h9a06_0084, 8'h85, 5'h01},
    '{32'h9828_0000, 8'h00, 5'h11}, '{32'h9820_0000, 8'h00, 5'h10},
    '{32'h980a_0000, 8'h00, 5'h0d}, '{32'h9a0b_0000, 8'h00, 5'h03}};
  sfsc_core u_sfsc_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .fetch_req, .fetch_addr, .fetch_ack, .fetch_word0, .fetch_word1,
    .tbl_req, .tbl_addr, .tbl_ack, .tbl_data, .bus_phase, .phase_req, .atn_in, .alu_carry,
    .arb_req, .arb_id, .arb_won, .arb_lost, .sel_req, .sel_reselect, .sel_atn, .sel_dest_id,
    .sync_period, .sync_offset, .sel_done, .int_halt, .int_fly);
  sfsc_peer u_sfsc_peer (.pclk, .fetch_req, .fetch_addr, .fetch_ack, .fetch_word0,
    .fetch_word1, .tbl_req, .tbl_addr, .tbl_ack, .tbl_data, .arb_req, .arb_won, .arb_lost,
    .sel_req, .sel_done, .slow, .lose);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (sel_req) cap <= {8'h0, sync_period, sync_offset, 3'h0, sel_reselect, sel_atn, sel_dest_id};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test;
    end
  end
  task end_of_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input [31:0] s, input [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s exp %h seen %h", nm, e, s);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task go(input [7:0] a, input wt);
    int k;
    apb(1'b1, `SFSC_IP_OFS, {24'h0, a});
    if (wt) begin
      repeat (4) @(posedge pclk);
      chk("waiting", {31'h0, int_halt}, 32'h0);
      phase_req <= 1'b1;
      @(posedge pclk);
      phase_req <= 1'b0;
    end
    for (k = 0; k < 300 && int_halt !== 1'b1; k++) @(posedge pclk);
    apb(1'b0, `SFSC_VEC_OFS, 32'h0);
  endtask
  task ld(input [3:0] i, input [31:0] a, input [31:0] b);
    u_sfsc_peer.m0[i] = a;
    u_sfsc_peer.m1[i] = b;
  endtask
  initial begin
    {psel, penable, pwrite, phase_req, atn_in, alu_carry, slow, lose} = 8'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    bus_phase = 3'h2;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `SFSC_VEC_OFS, 32'h0);
    chk("vector reset", d, 32'h0);
    ld(1, 32'h9808_0000, 32'hf00);
    foreach (rows[i]) begin
      {alu_carry, atn_in} <= rows[i].f[4:3];
      slow <= i[0];
      apb(1'b1, `SFSC_FRB_OFS, {24'h0, rows[i].b});
      apb(1'b1, `SFSC_CTRL_OFS, {31'h0, rows[i].f[2]});
      ld(0, rows[i].w, 32'ha0 + i);
      go(8'h00, rows[i].f[1]);
      chk("vector", d, rows[i].f[0] ? 32'ha0 + i : 32'hf00);
      $display("row %0d done", i);
    end
    {atn_in, alu_carry} <= 2'h0;
    apb(1'b1, `SFSC_CTRL_OFS, 32'h0);
    apb(1'b1, `SFSC_OID_OFS, 32'h3);
    apb(1'b1, `SFSC_TBL_OFS, 32'h100);
    ld(0, 32'h8808_0000, 32'h20);
    ld(1, 32'ha008_0000, 32'h0);
    ld(2, 32'h4105_0000, 32'h40);
    ld(3, 32'h9808_0000, 32'h77);
    ld(4, 32'h9008_0000, 32'h0);
    ld(5, 32'h4405_0000, 32'h00ff_ffe8);
    ld(6, 32'h8088_0000, 32'h18);
    ld(8, 32'h9808_0000, 32'h88);
    ld(9, 32'h4a00_0010, 32'h40);
    ld(10, 32'h9808_0000, 32'h99);
    go(8'h00, 1'b0);
    chk("vector", d, 32'h77);
    chk("fly", {31'h0, int_fly}, 32'h1);
    chk("own id", {29'h0, arb_id}, 32'h3);
    chk("select", {27'h0, cap[4:0]}, 32'h0d);
    apb(1'b0, `SFSC_RET_OFS, 32'h0);
    chk("return holder", d, 32'h8);
    $display("call select done");
    apb(1'b1, `SFSC_STAT_OFS, 32'h4);
    chk("fly clear", {31'h0, int_fly}, 32'h0);
    lose <= 1'b1;
    go(8'h10, 1'b0);
    chk("lost vector", d, 32'h88);
    go(8'h28, 1'b0);
    chk("relative vector", d, 32'h77);
    go(8'h30, 1'b0);
    chk("jump vector", d, 32'h99);
    $display("lost arbitration done");
    lose <= 1'b0;
    apb(1'b1, `SFSC_CTRL_OFS, 32'h1);
    go(8'h48, 1'b0);
    chk("reselect vector", d, 32'h99);
    chk("table fields", cap, 32'h0022_1016);
    apb(1'b1, `SFSC_IP_OFS, 32'h10);
    repeat (10) @(posedge pclk);
    apb(1'b0, `SFSC_STAT_OFS, 32'h0);
    chk("wrong role", {31'h0, d[`SFSC_ST_ILL]}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped read", d, 32'h0);
    chk("unmapped refused", {31'h0, sl}, 32'h1);
    $display("role and unmapped done");
    end_of_test;
  end
endmodule
